// ==== src/vfd_shift_latch_driver.sv ====
// vfd 40-stage shift/latch driver with an axi4-lite status and control slave
`timescale 1ns/1ns
module vfd_shift_latch_driver #(
  parameter int unsigned N = vfd_pkg::NUM_STAGES
) (
  // system clock, reset and enable
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  // axi4-lite write address
  input  wire logic [vfd_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // axi4-lite write data
  input  wire logic [vfd_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read address
  input  wire logic [vfd_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // axi4-lite read data
  output logic [vfd_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // serial link, on its own clock
  input  wire logic                        sclk,
  input  wire logic                        sdin,
  input  wire logic                        shift_right,
  output logic                             sdout,
  // asynchronous control pins
  input  wire logic                        latch_strobe,
  input  wire logic                        blank_n,
  input  wire logic                        force_all_high,
  // display drive
  output logic [N-1:0]                     driver_output
);
  import vfd_pkg::*;

  // register map, one aligned 32-bit word each:
  //   ctrl      bit 0 software blank, read/write, clear after reset
  //   status    bit 0 strobe, bit 1 blank_n, bit 2 force, bit 3 image settled
  //   stage lo  stages 1..32, stage 1 in bit 0
  //   stage hi  stages 33..40 in bits 7:0, upper bits zero
  //   latch     same split as the stage image
  //   drive     same split, the registered driver outputs
  // any other address answers slverr and reads as zero
  //
  // bus timing seen from the master:
  //   write  each ready one cycle after its own valid, bvalid two cycles after the later
  //   read   ready one cycle after arvalid, rvalid on the next cycle
  //   every ready is a one-cycle pulse; answers stand until taken
  //
  // display pins, with their latency in mclk edges:
  //   strobe  two to sync, one into the latch, one to the driver flop
  //   blank_n and force  two to sync, one to the driver flop
  // limitation: the latch is sampled, not truly transparent, so a strobe
  // shorter than one mclk period may fall between edges and be missed
  //
  // clock enable: low freezes every mclk flop, bus included; the link
  // side keeps shifting, since the host owns its clock

  // only whole aligned words decode; a byte inside a word misses
  // map a byte address onto a register select
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_CTRL:     decode = REG_CTRL;
      OFF_STATUS:   decode = REG_STATUS;
      OFF_STAGE_LO: decode = REG_STAGE_LO;
      OFF_STAGE_HI: decode = REG_STAGE_HI;
      OFF_LATCH_LO: decode = REG_LATCH_LO;
      OFF_LATCH_HI: decode = REG_LATCH_HI;
      OFF_DRIVE_LO: decode = REG_DRIVE_LO;
      OFF_DRIVE_HI: decode = REG_DRIVE_HI;
      default:      decode = REG_NONE;
    endcase
  endfunction

  // the shift keeps this right for any width from 33 to 64 stages
  // upper stages placed in the low bits, rest zero
  function automatic logic [DATA_W-1:0] hi_word(input logic [N-1:0] v);
    hi_word = DATA_W'(v >> DATA_W);
  endfunction

  // ---------------- link side ----------------
  // no enable and no reset on the stages: a power-up pattern is garbage
  // until a full frame has gone through, which is why the host keeps the
  // display blanked until the first strobe
  shift_if sh ();  // stage image and cascade flop

  // shift register lives entirely on sclk
  shift_link #(
    .N (N)
  ) u_link (
    .sclk        (sclk),
    .rst_n       (rst_n),
    .sdin        (sdin),
    .shift_right (shift_right),
    .sh          (sh)
  );

  assign sdout = sh.sdout;  // straight from the link-side flop

  // ---------------- crossings into mclk ----------------
  // hazard: the stage image is 40 independent bits on another clock, and a
  // word sampled mid-shift can mix old and new bits; rather than a full
  // handshake a word is accepted only after two identical samples, which
  // costs one mclk cycle of latency and nothing else
  logic [2:0]   pins_s;        // {force, blank_n, strobe} after two flops
  logic [N-1:0] stage_s;       // stage image after two flops
  logic [N-1:0] stage_prev_q;  // one more sample to prove it has settled

  // the pins come straight from the host and may move at any instant, so
  // each passes two flops before any logic reads it; the reset value keeps
  // the outputs blanked until the real pin levels have come through
  // pins start in the blanked state so nothing lights before software/host acts
  sync_bits #(
    .W   (3),
    .RST (PINS_RST)
  ) u_pin_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in ({force_all_high, blank_n, latch_strobe}),
    .sync_out (pins_s)
  );

  // the stage word is quasi-static around a strobe, so per-bit sync plus a
  // stability compare is enough; a word caught mid-shift is simply not taken
  sync_bits #(
    .W   (N),
    .RST ('0)
  ) u_stage_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in (sh.stage_value),
    .sync_out (stage_s)
  );

  wire strobe_s = pins_s[0];
  wire blank_ns = pins_s[1];
  wire force_s  = pins_s[2];
  wire stable   = (stage_s == stage_prev_q);  // two equal samples in a row

  // ---------------- latch and driver ----------------
  logic [N-1:0]        latch_q;  // latch contents
  logic [N-1:0]        drv_d;    // next driver value
  logic [DATA_W-1:0]   ctrl_q;   // control register
  wire                 sw_blank = ctrl_q[CTRL_SW_BLANK];

  // software blank gives a way to dark the tube without touching the pin,
  // at the cost of one more term in front of every output
  // blank dominates, then force, then latch; software blank acts like the pin
  assign drv_d = (!blank_ns || sw_blank) ? {N{1'b0}} :
                 force_s                 ? {N{1'b1}} :
                                           latch_q;

  // transparent while strobe high, holding otherwise; the host keeps the link
  // idle around the strobe, which also lets the settled check pass
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage_prev_q <= '0;
      latch_q      <= '0;
    end else if (ce) begin
      stage_prev_q <= stage_s;
      if (strobe_s && stable) begin
        latch_q <= stage_s;
      end
    end
  end

  // registering the drive costs one cycle but keeps the outputs glitch
  // free while blank and force change under the synchronisers
  // every driver output comes from this flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      driver_output <= '0;
    end else if (ce) begin
      driver_output <= drv_d;
    end
  end

  // ---------------- axi4-lite write path ----------------
  // address and data may arrive in either order or together; each is
  // parked in its own holding flop, and the write commits only when both
  // are held and no earlier response is still waiting for bready
  logic              aw_full_q;  // address held, waiting for data
  logic              w_full_q;   // data held, waiting for address
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire wr_fire  = aw_full_q && w_full_q && !s_axi_bvalid;
  wire wr_ctrl  = wr_fire && (decode(awaddr_q) == REG_CTRL);
  wire wr_map   = (decode(awaddr_q) == REG_CTRL) || (decode(awaddr_q) == REG_STATUS);

  // address and data are taken independently, in the same cycle or apart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else if (ce) begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_full_q && !s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_full_q && !s_axi_bvalid;
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // bresp comes from the held address, so a late data beat cannot
  // change the answer for the address it belongs to
  // commit and answer; status and image registers ignore writes quietly
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q       <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_ctrl && wstrb_q[0]) begin
        ctrl_q[CTRL_SW_BLANK] <= wdata_q[CTRL_SW_BLANK];  // only bit 0 is writable
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_map || decode(awaddr_q) != REG_NONE) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- axi4-lite read path ----------------
  // reads have no side effects, so the select decodes the live address and
  // the answer is captured at the same edge that takes the address
  // status packs the synchronised pin levels and the settled flag, so
  // software can poll for a quiet link before asking the host to strobe
  reg_sel_e          rd_sel;
  logic [DATA_W-1:0] rd_data;
  wire               ar_take = s_axi_arvalid && s_axi_arready;

  assign rd_sel  = decode(s_axi_araddr);
  assign rd_data = (rd_sel == REG_CTRL)     ? ctrl_q :
                   (rd_sel == REG_STATUS)   ? DATA_W'({stable, force_s, blank_ns, strobe_s}) :
                   (rd_sel == REG_STAGE_LO) ? stage_s[DATA_W-1:0] :
                   (rd_sel == REG_STAGE_HI) ? hi_word(stage_s) :
                   (rd_sel == REG_LATCH_LO) ? latch_q[DATA_W-1:0] :
                   (rd_sel == REG_LATCH_HI) ? hi_word(latch_q) :
                   (rd_sel == REG_DRIVE_LO) ? driver_output[DATA_W-1:0] :
                   (rd_sel == REG_DRIVE_HI) ? hi_word(driver_output) :
                                              '0;

  // arready stays low while an answer waits for rready
  // one read at a time; arready pulses, data follows on the next edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== src/vfd_pkg.sv ====
// shared constants for the vfd shift/latch driver and its register slave
package vfd_pkg;
  localparam int unsigned NUM_STAGES    = 40;          // shift register, latch and driver width
  localparam int unsigned ADDR_W        = 8;           // register bus address width
  localparam int unsigned DATA_W        = 32;          // register bus data width
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL      = 8'h00;       // control: software blank
  localparam logic [7:0]  OFF_STATUS    = 8'h04;       // synchronised pin levels
  localparam logic [7:0]  OFF_STAGE_LO  = 8'h08;       // shift stages 1..32
  localparam logic [7:0]  OFF_STAGE_HI  = 8'h0C;       // shift stages 33..40
  localparam logic [7:0]  OFF_LATCH_LO  = 8'h10;       // latches 1..32
  localparam logic [7:0]  OFF_LATCH_HI  = 8'h14;       // latches 33..40
  localparam logic [7:0]  OFF_DRIVE_LO  = 8'h18;       // driver outputs 1..32
  localparam logic [7:0]  OFF_DRIVE_HI  = 8'h1C;       // driver outputs 33..40
  // field positions
  localparam int unsigned CTRL_SW_BLANK = 0;           // ctrl: force all outputs low
  localparam int unsigned ST_STROBE     = 0;           // status: latch strobe level
  localparam int unsigned ST_BLANK_N    = 1;           // status: blank_n level
  localparam int unsigned ST_FORCE      = 2;           // status: force_all_high level
  localparam int unsigned ST_STABLE     = 3;           // status: stage image settled
  // values after reset
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [2:0]  PINS_RST      = 3'h0;        // {force, blank_n, strobe}: blanked low
  // bus response codes
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // register index decode
  typedef enum logic [3:0] {
    REG_CTRL     = 4'b0000,
    REG_STATUS   = 4'b0001,
    REG_STAGE_LO = 4'b0010,
    REG_STAGE_HI = 4'b0011,
    REG_LATCH_LO = 4'b0100,
    REG_LATCH_HI = 4'b0101,
    REG_DRIVE_LO = 4'b0110,
    REG_DRIVE_HI = 4'b0111,
    REG_NONE     = 4'b1111
  } reg_sel_e;
endpackage

// ==== src/shift_if.sv ====
// carrier between the link-side shift register and the core
`timescale 1ns/1ns
interface shift_if;
  logic [vfd_pkg::NUM_STAGES-1:0] stage_value;  // parallel view of all stages
  logic                           sdout;        // cascade output flop
  modport link (output stage_value, output sdout);
  modport core (input stage_value, input sdout);
endinterface

// ==== src/sync_bits.sv ====
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ns
module sync_bits #(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock, reset and enable
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // levels in and out
  input  wire logic [W-1:0] async_in,
  output logic [W-1:0]      sync_out
);
  logic [W-1:0] meta_q;  // first stage, read by the second stage only

  // two stages; metastability settles in the first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= RST;
      sync_out <= RST;
    end else if (ce) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== src/shift_link.sv ====
// bidirectional shift register running on the link clock
`timescale 1ns/1ns
module shift_link #(
  parameter int unsigned N = vfd_pkg::NUM_STAGES
) (
  // link clock and reset for the cascade flop
  input  wire logic sclk,
  input  wire logic rst_n,
  // serial inputs, sampled on sclk
  input  wire logic sdin,
  input  wire logic shift_right,
  // parallel and cascade outputs
  shift_if.link     sh
);
  logic [N-1:0] stage_q;  // no reset: contents undefined until shifted
  logic [N-1:0] stage_d;
  logic         sdout_d;

  // stage 1 is bit 0; right moves toward stage N, left toward stage 1
  assign stage_d = shift_right ? {stage_q[N-2:0], sdin}
                               : {sdin, stage_q[N-1:1]};
  // end stage of the new contents, chosen by the direction at this edge
  assign sdout_d = shift_right ? stage_d[N-1] : stage_d[0];

  // stages change only on a rising link edge, so they hold otherwise
  always_ff @(posedge sclk) begin
    stage_q <= stage_d;
  end

  // cascade flop; registered so it too only moves on an edge
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      sh.sdout <= 1'b0;
    end else begin
      sh.sdout <= sdout_d;
    end
  end

  assign sh.stage_value = stage_q;
endmodule

// ==== dv/vfd_chk.sv ====
// checker on the vfd driver's link and display ports
`timescale 1ns/1ns
module vfd_chk #(
  parameter int unsigned N = vfd_pkg::NUM_STAGES
) (
  // clocks and reset
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire logic         sclk,
  // serial link
  input wire logic         sdin,
  input wire logic         shift_right,
  input wire logic         sdout,
  // display pins and drive
  input wire logic         latch_strobe,
  input wire logic         blank_n,
  input wire logic         force_all_high,
  input wire logic [N-1:0] driver_output
);
  import vfd_pkg::*;
  logic [5:0] run_r_q;  // link edges in a row shifting toward stage 40
  logic [5:0] run_l_q;  // link edges in a row shifting toward stage 1
  logic       neg_q;    // sdout as seen at the last falling link edge
  // count runs per direction; a full run means sdout is pure cascade
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      run_r_q <= '0;
      run_l_q <= '0;
    end else begin
      run_r_q <= shift_right ? run_r_q + {5'h0, run_r_q != 6'h28} : 6'h0;
      run_l_q <= shift_right ? 6'h0 : run_l_q + {5'h0, run_l_q != 6'h28};
    end
  end
  // falling-edge snapshot, so a move between rising edges shows up
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) neg_q <= 1'h0;
    else neg_q <= sdout;
  end
  // pin levels held long enough to pass both sync flops and the driver flop
  sequence blank_held;
    !blank_n [*3];
  endsequence
  sequence force_held;
    (blank_n && force_all_high) [*3];
  endsequence
  sequence strobe_quiet;
    (!latch_strobe && blank_n && !force_all_high) [*6];
  endsequence
  a_right_cascade: assert property (@(posedge sclk) disable iff (!rst_n)
    run_r_q == 6'h28 |-> sdout == $past(sdin, 40)) else $error("right cascade wrong");
  a_left_cascade: assert property (@(posedge sclk) disable iff (!rst_n)
    run_l_q == 6'h28 |-> sdout == $past(sdin, 40)) else $error("left cascade wrong");
  a_sdout_hold: assert property (@(posedge sclk) disable iff (!rst_n)
    sdout == neg_q) else $error("sdout moved without a rising link edge");
  a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    strobe_quiet |=> $stable(driver_output)) else $error("latch moved with strobe low");
  a_blank_low: assert property (@(posedge mclk) disable iff (!rst_n)
    blank_held |=> driver_output == '0) else $error("blanking not applied");
  a_force_high: assert property (@(posedge mclk) disable iff (!rst_n)
    force_held |=> &driver_output) else $error("force all high not applied");
endmodule

// ==== dv/vfd_host.sv ====
// host model: serial link, latch strobe and display pins
`timescale 1ns/1ns
module vfd_host (
  // system clock for pin timing
  input wire logic mclk,
  // link and pin drives
  output logic     sclk,
  output logic     sdin,
  output logic     shift_right,
  output logic     latch_strobe,
  output logic     blank_n,
  output logic     force_all_high
);
  // power-up: link idle, display held blank until data is latched
  initial begin
    sclk           = 1'h0;
    sdin           = 1'h0;
    shift_right    = 1'h0;
    latch_strobe   = 1'h0;
    blank_n        = 1'h0;
    force_all_high = 1'h0;
  end
  // one frame of 40 bits; the word lands in stage order either way
  task automatic send_frame(input logic [39:0] w, input logic dir);
    #37;
    for (int j = 0; j < 40; j++) begin
      sdin        <= dir ? w[39-j] : w[j];
      shift_right <= dir;
      #62 sclk = 1'h1;
      #63 sclk = 1'h0;
    end
    sdin <= ~sdin; // released line shows the inverse, not the last bit
  endtask
  // strobe only after a whole frame and a quiet link
  task automatic strobe_pulse();
    repeat (6) @(posedge mclk);
    latch_strobe <= 1'h1;
    repeat (4) @(posedge mclk);
    latch_strobe <= 1'h0;
    repeat (6) @(posedge mclk);
  endtask
  // move blanking and force, then let the sync chain settle
  task automatic set_pins(input logic b, input logic f);
    @(posedge mclk);
    blank_n        <= b;
    force_all_high <= f;
    repeat (5) @(posedge mclk);
  endtask
endmodule

// ==== dv/vfd_shift_latch_driver_tb_top.sv ====
// self-checking bench for the vfd shift/latch driver
`timescale 1ns/1ns
module vfd_shift_latch_driver_tb_top;
  import vfd_pkg::*;
  logic                  mclk = 1'h0, rst_n, ce = 1'h1;           // clock, reset, run enable
  logic [7:0]            s_axi_awaddr = '0, s_axi_araddr = '0;   // bus addresses
  logic [31:0]           s_axi_wdata = '0, s_axi_rdata;          // bus data
  logic [3:0]            s_axi_wstrb = 4'hf;                     // whole words only
  logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]            s_axi_bresp, s_axi_rresp;               // response codes
  logic                  sclk, sdin, shift_right, sdout;         // serial link
  logic                  latch_strobe, blank_n, force_all_high;  // host pins
  logic [NUM_STAGES-1:0] driver_output, w1, w2;                  // drive and frame words
  integer                seed = 32'hc9a4_6ff1;                   // fixed seed
  int                    checked = 0, miscompares = 0;           // tallies
  logic [33:0]           rd_q[$];                                // expected {rdata, rresp}
  logic [1:0]            wr_q[$];                                // expected bresp
  always #50 mclk = ~mclk;
  vfd_shift_latch_driver u_vfd_shift_latch_driver (.*);
  vfd_host u_vfd_host (.*);
  // one comparison, four-state; an unknown matches only an unknown
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (e !== g) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // bus read: note the answer, hold each channel until taken
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rd_q.push_back({d, r});
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge mclk);
    s_axi_rready <= 1'h0;
  endtask
  // bus write: address and data offered together, released apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw = 1'b1;
    bit wv = 1'b1;
    wr_q.push_back(r);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (aw || wv) begin
      @(posedge mclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'h0;
        aw = 1'b0;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'h0;
        wv = 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge mclk);
    s_axi_bready <= 1'h0;
  endtask
  // match each bus answer against the oldest note
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("read", {6'h0, rd_q.pop_front()}, {6'h0, s_axi_rdata, s_axi_rresp});
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {38'h0, wr_q.pop_front()}, {38'h0, s_axi_bresp});
  end
  // verdict, reached from the sequence or the watchdog
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    rst_n <= 1'h0;                    // a real falling edge, so the link-side cascade flop resets too
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    rd(OFF_CTRL, CTRL_RST, RESP_OKAY);
    rd(8'h20, '0, RESP_SLVERR);          // unmapped read
    wr(8'h24, 32'h1, RESP_SLVERR);       // unmapped write
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    rd(OFF_CTRL, 32'h1, RESP_OKAY);
    wr(OFF_CTRL, '0, RESP_OKAY);
    wr(OFF_STATUS, 32'hf, RESP_OKAY);    // read-only, ignored
    chk("drv_blank", '0, driver_output);
    w1 = 40'({$random(seed), $random(seed)});
    u_vfd_host.send_frame(w1, 1'h1);
    chk("sdout_right", {39'h0, w1[39]}, {39'h0, sdout});
    u_vfd_host.strobe_pulse();
    rd(OFF_STAGE_LO, w1[31:0], RESP_OKAY);
    rd(OFF_LATCH_HI, {24'h0, w1[39:32]}, RESP_OKAY);
    rd(OFF_DRIVE_LO, '0, RESP_OKAY);
    u_vfd_host.set_pins(1'h1, 1'h0);
    rd(OFF_STATUS, 32'ha, RESP_OKAY);
    chk("drv_latch", w1, driver_output);
    w2 = 40'({$random(seed), $random(seed)});
    u_vfd_host.send_frame(w2, 1'h0);
    chk("sdout_left", {39'h0, w2[0]}, {39'h0, sdout});
    u_vfd_host.shift_right <= 1'h1;   // direction flips while the link idles
    repeat (8) @(posedge mclk);
    chk("sdout_idle", {39'h0, w2[0]}, {39'h0, sdout});
    rd(OFF_STAGE_HI, {24'h0, w2[39:32]}, RESP_OKAY);
    chk("drv_hold", w1, driver_output);
    u_vfd_host.set_pins(1'h1, 1'h1);
    chk("drv_force", '1, driver_output);
    u_vfd_host.set_pins(1'h0, 1'h1);
    chk("drv_clear", '0, driver_output);
    u_vfd_host.set_pins(1'h1, 1'h0);
    u_vfd_host.strobe_pulse();
    rd(OFF_DRIVE_HI, {24'h0, w2[39:32]}, RESP_OKAY);
    chk("drv_new", w2, driver_output);
    u_vfd_host.send_frame(w2, 1'h0);
    chk("sdout_again", {39'h0, w2[0]}, {39'h0, sdout});
    rst_n <= 1'h0;                    // second reset in mid-run
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (4) @(posedge mclk);
    rd(OFF_STAGE_LO, w2[31:0], RESP_OKAY);
    stop_test();
  end
  // watchdog: the sequence needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    stop_test();
  end
endmodule
bind vfd_shift_latch_driver vfd_chk #(.N(N)) u_vfd_chk (
  .mclk (mclk), .rst_n (rst_n), .sclk (sclk), .sdin (sdin), .shift_right (shift_right), .sdout (sdout),
  .latch_strobe (latch_strobe), .blank_n (blank_n), .force_all_high (force_all_high),
  .driver_output (driver_output)
);
